// ---- design/mqpr_pkg.sv ----
// Shared constants and types for the multi-queue packet readout pair.
// Assumes both ends run on one clock and meet in mqpr_link_if.
package mqpr_pkg;
  localparam int QUEUE_COUNT = 8;           // Number of queues
  localparam int QADDR_WIDTH = 3;           // Queue address width
  localparam int DATA_WIDTH = 36;           // Output bus width
  localparam int PAYLOAD_WIDTH = 32;        // Data bits below the markers
  localparam int DEPTH = 16;                // Words per queue
  localparam int PTR_WIDTH = 4;             // Pointer width
  localparam int AE_LEVEL = 2;              // Almost-empty at or below this count
  localparam int PRS_SETUP_CYCLES = 2;      // Queue select lead before partial reset
  localparam int START_BIT = 32;            // Start marker bit position
  localparam int END_BIT = 33;              // End marker bit position
  // Host controller command port offsets
  localparam logic [3:0] REG_CTRL = 4'h0;   // Mode strap, partial reset request
  localparam logic [3:0] REG_WSEL = 4'h1;   // Write queue select
  localparam logic [3:0] REG_RSEL = 4'h2;   // Read queue select
  localparam logic [3:0] REG_WDATA = 4'h3;  // Write word with markers
  localparam logic [3:0] REG_RDATA = 4'h4;  // Last word read
  localparam logic [3:0] REG_STATUS = 4'h5; // Flags
  localparam logic [3:0] REG_IRQ = 4'h6;    // Sticky events
  localparam logic [3:0] REG_MASK = 4'h7;   // Event mask
  localparam logic [3:0] REG_READ = 4'h8;   // Write any value to pop one word
  typedef enum logic [1:0] {PRS_IDLE_type_v, PRS_WAIT_type_v, PRS_PULSE_type_v} mqpr_prs_type;
endpackage : mqpr_pkg

// ---- design/mqpr_link_if.sv ----
// Pins between the queue device and its host controller.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps
interface mqpr_link_if;
  import mqpr_pkg::*;
  logic packet_select_strap;                    // High selects packet mode
  logic master_reset_n;                         // Device master reset
  logic queue_partial_reset_n;                  // One-cycle partial reset
  logic write_enable_n;                         // Write strobe
  logic [QADDR_WIDTH-1:0] write_queue_address;  // Write queue
  logic write_queue_select_enable;              // Latch write queue
  logic [DATA_WIDTH-1:0] write_data;            // Word with markers
  logic read_enable_n;                          // Read strobe
  logic output_enable_n;                        // Output enable
  logic [QADDR_WIDTH-1:0] read_queue_address;   // Read queue
  logic read_queue_select_enable;               // Latch read queue
  logic [DATA_WIDTH-1:0] read_data;             // Output bus
  logic output_valid_n;                         // Low when word valid
  logic packet_ready_n;                         // Low when packet ready
  logic almost_empty_n;                         // Low when almost empty
  logic [QUEUE_COUNT-1:0] read_flag_bus;        // Per-queue flags
  modport device (
    input packet_select_strap, master_reset_n, queue_partial_reset_n,
    input write_enable_n, write_queue_address, write_queue_select_enable, write_data,
    input read_enable_n, output_enable_n, read_queue_address, read_queue_select_enable,
    output read_data, output_valid_n, packet_ready_n, almost_empty_n, read_flag_bus
  );
  modport host (
    output packet_select_strap, master_reset_n, queue_partial_reset_n,
    output write_enable_n, write_queue_address, write_queue_select_enable, write_data,
    output read_enable_n, output_enable_n, read_queue_address, read_queue_select_enable,
    input read_data, output_valid_n, packet_ready_n, almost_empty_n, read_flag_bus
  );
endinterface : mqpr_link_if

// ---- design/mqpr_device.sv ----
// Multi-queue memory with packet-ready and almost-empty flags, and partial reset.
// Assumes the host keeps its side of the link; one clock serves write and read.
// Writes to a full queue and reads from an empty queue are dropped.
// Partial reset acts on the queue selected on the read port.
// Behaviour
// - strap at master reset picks packet mode
// - packet mode: flag bus shows packet ready
// - almost-empty mode: bus almost-empty, ready inactive
// - packet mode only with 36-bit ports
// - writer marks packet start and end words
// - ready low when a complete packet stored
// - ready follows queue selected for reading
// - ready plus valid means packet readable
// - writer finishes packet before switching queue
// - select target queue two cycles before reset
// - partial reset held low one cycle
// - partial reset clears selected queue pointers only
// - read word when read, output enables low
// - top four bits carry packet markers
// - almost-empty low for selected read queue
// - read address latched while select enable high
`timescale 1ns/100ps
module mqpr_device (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link to the host
  mqpr_link_if.device link
);
  import mqpr_pkg::*;
  // Count width holds zero up to a full queue
  localparam int CW = PTR_WIDTH + 1;  // Count width

  logic [DATA_WIDTH-1:0] mem_q [QUEUE_COUNT][DEPTH];  // Storage
  logic [DATA_WIDTH-1:0] mem_d [QUEUE_COUNT][DEPTH];
  logic [PTR_WIDTH-1:0] wptr_q [QUEUE_COUNT];  // Write pointers
  logic [PTR_WIDTH-1:0] wptr_d [QUEUE_COUNT];
  logic [PTR_WIDTH-1:0] rptr_q [QUEUE_COUNT];  // Read pointers
  logic [PTR_WIDTH-1:0] rptr_d [QUEUE_COUNT];
  logic [CW-1:0] cnt_q [QUEUE_COUNT];          // Word counts
  logic [CW-1:0] cnt_d [QUEUE_COUNT];
  logic [CW-1:0] pkts_q [QUEUE_COUNT];         // Complete packets stored
  logic [CW-1:0] pkts_d [QUEUE_COUNT];
  logic pkt_mode_q, pkt_mode_d;                // Mode caught from strap
  logic [QADDR_WIDTH-1:0] wsel_q, wsel_d;      // Write queue
  logic [QADDR_WIDTH-1:0] rsel_q, rsel_d;      // Read queue
  logic rsel_valid_q, rsel_valid_d;            // A read queue has been chosen
  logic [DATA_WIDTH-1:0] rdata_q, rdata_d;     // Output register
  logic ov_n_q, ov_n_d;                        // Output valid, active low
  logic [QUEUE_COUNT-1:0] ready_vec;           // Per-queue packet ready (high true)
  logic [QUEUE_COUNT-1:0] ae_vec;              // Per-queue almost empty (high true)
  logic do_write, do_read;                     // Accepted strobes

  // Per-queue status
  always_comb begin
    for (int i = 0; i < QUEUE_COUNT; i++) begin
      // Ready counts whole packets; almost empty is a count threshold
      ready_vec[i] = (pkts_q[i] != '0);
      ae_vec[i] = (cnt_q[i] <= CW'(AE_LEVEL));
    end
  end

  // Strobes gated by mode-independent enables; none while master reset holds
  always_comb begin
    do_write = link.master_reset_n && !link.write_enable_n
               && (cnt_q[wsel_q] != CW'(DEPTH));
    do_read = link.master_reset_n && !link.read_enable_n && !link.output_enable_n
              && rsel_valid_q && (cnt_q[rsel_q] != '0);
  end

  // Next state of queue storage, pointers and counts
  always_comb begin
    // Hold every queue unless changed below
    mem_d = mem_q;
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    cnt_d = cnt_q;
    pkts_d = pkts_q;
    // Master reset empties every queue
    if (!link.master_reset_n) begin
      for (int i = 0; i < QUEUE_COUNT; i++) begin
        wptr_d[i] = '0;
        rptr_d[i] = '0;
        cnt_d[i] = '0;
        pkts_d[i] = '0;
      end
    end else begin
      // Write side
      if (do_write) begin
        mem_d[wsel_q][wptr_q[wsel_q]] = link.write_data;
        wptr_d[wsel_q] = wptr_q[wsel_q] + 1'b1;
        cnt_d[wsel_q] = cnt_d[wsel_q] + 1'b1;
        // Count the packet once its end word lands
        if (link.write_data[END_BIT]) begin
          pkts_d[wsel_q] = pkts_d[wsel_q] + 1'b1;
        end
      end
      // Read side; the word itself goes to the output group
      if (do_read) begin
        rptr_d[rsel_q] = rptr_q[rsel_q] + 1'b1;
        cnt_d[rsel_q] = cnt_d[rsel_q] - 1'b1;
        // A packet leaves the queue when its end word is read
        if (mem_q[rsel_q][rptr_q[rsel_q]][END_BIT] && pkts_d[rsel_q] != '0) begin
          pkts_d[rsel_q] = pkts_d[rsel_q] - 1'b1;
        end
      end
      // Partial reset of the queue selected on the read port only
      // It overrides a same-cycle write or read on that queue; a written word is lost, a read word still goes out
      if (!link.queue_partial_reset_n) begin
        wptr_d[rsel_q] = '0;
        rptr_d[rsel_q] = '0;
        cnt_d[rsel_q] = '0;
        pkts_d[rsel_q] = '0;
      end
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Storage is cleared too, so nothing unknown reaches the output
      for (int i = 0; i < QUEUE_COUNT; i++) begin
        wptr_q[i] <= '0;
        rptr_q[i] <= '0;
        cnt_q[i] <= '0;
        pkts_q[i] <= '0;
        for (int j = 0; j < DEPTH; j++) begin
          mem_q[i][j] <= '0;
        end
      end
    end else begin
      mem_q <= mem_d;
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
      pkts_q <= pkts_d;
    end
  end

  // Mode strap and queue selects; master reset forgets the read queue
  always_comb begin
    pkt_mode_d = pkt_mode_q;
    wsel_d = wsel_q;
    rsel_d = rsel_q;
    rsel_valid_d = rsel_valid_q;
    // Only master reset changes the mode; a partial reset leaves it
    if (!link.master_reset_n) begin
      // Strap sampled while master reset is held; the last low cycle wins
      pkt_mode_d = link.packet_select_strap;
      rsel_valid_d = 1'b0;
    end else begin
      // Write queue select
      if (link.write_queue_select_enable) begin
        wsel_d = link.write_queue_address;
      end
      // Read queue select; flags follow it from the next cycle
      if (link.read_queue_select_enable) begin
        rsel_d = link.read_queue_address;
        rsel_valid_d = 1'b1;
      end
    end
  end

  // Mode and select registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Packet mode off and no read queue; mode then follows the strap while master reset holds
      pkt_mode_q <= 1'b0;
      wsel_q <= '0;
      rsel_q <= '0;
      rsel_valid_q <= 1'b0;
    end else begin
      pkt_mode_q <= pkt_mode_d;
      wsel_q <= wsel_d;
      rsel_q <= rsel_d;
      rsel_valid_q <= rsel_valid_d;
    end
  end

  // Output word: loaded on an accepted read, valid low for that one cycle
  always_comb begin
    rdata_d = rdata_q;
    ov_n_d = 1'b1;
    if (do_read) begin
      // Markers ride in the top bits beside the payload
      rdata_d = mem_q[rsel_q][rptr_q[rsel_q]];
      ov_n_d = 1'b0;
    end
  end

  // Output registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= '0;
      ov_n_q <= 1'b1;
    end else begin
      rdata_q <= rdata_d;
      ov_n_q <= ov_n_d;
    end
  end

  // Outputs: the word and its valid flag, flags of the selected read queue, and the per-queue flag bus
  // Registered word and its valid flag
  assign link.read_data = rdata_q;
  assign link.output_valid_n = ov_n_q;
  // Packet ready only in packet mode; idle high otherwise
  assign link.packet_ready_n = pkt_mode_q ? !(rsel_valid_q && ready_vec[rsel_q])
                                          : 1'b1;
  // Almost empty reads low until a read queue has been chosen
  assign link.almost_empty_n = rsel_valid_q && !ae_vec[rsel_q];
  // Every queue at once: ready in packet mode, almost empty otherwise
  assign link.read_flag_bus = pkt_mode_q ? ~ready_vec : ~ae_vec;
endmodule : mqpr_device

// ---- design/mqpr_host.sv ----
// Host controller driving the queue device link from a register port.
// Assumes software writes and reads over a plain strobe port on the same clock.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
module mqpr_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Software port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  output logic irq,
  // Link to the device
  mqpr_link_if.host link
);
  import mqpr_pkg::*;

  logic strap_q, strap_d;                    // Packet mode choice
  logic mrst_n_q, mrst_n_d;                  // Master reset drive
  logic [QADDR_WIDTH-1:0] wq_q, wq_d;        // Write queue
  logic [QADDR_WIDTH-1:0] rq_q, rq_d;        // Read queue
  logic wsel_en_q, wsel_en_d;                // Write select pulse
  logic rsel_en_q, rsel_en_d;                // Read select pulse
  logic wen_n_q, wen_n_d;                    // Write strobe
  logic ren_n_q, ren_n_d;                    // Read strobe
  // Write word, always the full width that packet mode needs
  logic [DATA_WIDTH-1:0] wd_q, wd_d;
  logic [DATA_WIDTH-1:0] cap_q, cap_d;       // Last word read
  logic in_packet_q, in_packet_d;            // Between start and end markers
  logic prs_n_q, prs_n_d;                    // Partial reset drive
  logic [1:0] prs_cnt_q, prs_cnt_d;          // Select lead counter
  mqpr_prs_type prs_st_q, prs_st_d;          // Partial reset sequence
  logic [2:0] irq_q, irq_d;                  // Sticky: word, ready, prs done
  logic [2:0] mask_q, mask_d;                // Event mask
  logic [31:0] rdata_q, rdata_d;             // Read data register
  logic [2:0] ev;                            // Events this cycle

  // Events seen on the link
  always_comb begin
    ev[0] = !link.output_valid_n;
    ev[1] = !link.packet_ready_n && !link.output_valid_n;
    ev[2] = (prs_st_q == PRS_PULSE_type_v);
  end

  // Command decode and sequencing
  always_comb begin
    strap_d = strap_q;
    mrst_n_d = mrst_n_q;
    wq_d = wq_q;
    rq_d = rq_q;
    wsel_en_d = 1'b0;
    rsel_en_d = 1'b0;
    wen_n_d = 1'b1;
    ren_n_d = 1'b1;
    wd_d = wd_q;
    cap_d = ev[0] ? link.read_data : cap_q;
    in_packet_d = in_packet_q;
    prs_n_d = 1'b1;
    prs_cnt_d = prs_cnt_q;
    prs_st_d = prs_st_q;
    mask_d = mask_q;
    irq_d = irq_q;
    rdata_d = '0;
    if (wr_stb && addr == REG_IRQ) begin
      irq_d = irq_q & ~wdata[2:0];
    end
    irq_d = irq_d | ev;  // Set wins over clear
    if (wr_stb) begin
      if (addr == REG_CTRL) begin
        strap_d = wdata[0];
        mrst_n_d = !wdata[1];
        if (wdata[2] && prs_st_q == PRS_IDLE_type_v) begin
          wq_d = rq_q;
          wsel_en_d = 1'b1;
          rsel_en_d = 1'b1;
          prs_cnt_d = '0;
          prs_st_d = PRS_WAIT_type_v;
        end
      end else if (addr == REG_WSEL) begin
        if (!in_packet_q) begin
          wq_d = wdata[QADDR_WIDTH-1:0];
          wsel_en_d = 1'b1;
        end
      end else if (addr == REG_RSEL) begin
        rq_d = wdata[QADDR_WIDTH-1:0];
        rsel_en_d = 1'b1;
      end else if (addr == REG_WDATA) begin
        wd_d = {2'h0, wdata[5:4], wd_q[PAYLOAD_WIDTH-1:0]};
        wen_n_d = 1'b0;
        if (wdata[5]) begin
          in_packet_d = 1'b0;
        end else if (wdata[4]) begin
          in_packet_d = 1'b1;
        end
      end else if (addr == REG_MASK) begin
        mask_d = wdata[2:0];
      end else if (addr == REG_READ) begin
        ren_n_d = 1'b0;
      end else if (addr == REG_STATUS) begin
        wd_d = {wd_q[DATA_WIDTH-1:PAYLOAD_WIDTH], wdata};
      end
    end
    // Partial reset: wait out the select lead, then one low cycle
    case (prs_st_q)
      PRS_WAIT_type_v: begin
        prs_cnt_d = prs_cnt_q + 1'b1;
        if (prs_cnt_q == 2'(PRS_SETUP_CYCLES)) begin
          prs_n_d = 1'b0;
          prs_st_d = PRS_PULSE_type_v;
        end
      end
      PRS_PULSE_type_v: begin
        prs_st_d = PRS_IDLE_type_v;
      end
      default: begin
        prs_st_d = prs_st_d;
      end
    endcase
    if (rd_stb) begin
      if (addr == REG_CTRL) begin
        rdata_d = {29'h0, prs_st_q != PRS_IDLE_type_v, !mrst_n_q, strap_q};
      end else if (addr == REG_RDATA) begin
        rdata_d = cap_q[31:0];
      end else if (addr == REG_STATUS) begin
        rdata_d = {16'h0, link.read_flag_bus, 4'h0, cap_q[END_BIT:START_BIT],
                   !link.almost_empty_n, !link.packet_ready_n};
      end else if (addr == REG_IRQ) begin
        rdata_d = {29'h0, irq_q};
      end else if (addr == REG_MASK) begin
        rdata_d = {29'h0, mask_q};
      end
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_q <= 1'b0;
      mrst_n_q <= 1'b0;
      wq_q <= '0;
      rq_q <= '0;
      wsel_en_q <= 1'b0;
      rsel_en_q <= 1'b0;
      wen_n_q <= 1'b1;
      ren_n_q <= 1'b1;
      wd_q <= '0;
      cap_q <= '0;
      in_packet_q <= 1'b0;
      prs_n_q <= 1'b1;
      prs_cnt_q <= '0;
      prs_st_q <= PRS_IDLE_type_v;
      irq_q <= '0;
      mask_q <= '0;
      rdata_q <= '0;
    end else begin
      strap_q <= strap_d;
      mrst_n_q <= mrst_n_d;
      wq_q <= wq_d;
      rq_q <= rq_d;
      wsel_en_q <= wsel_en_d;
      rsel_en_q <= rsel_en_d;
      wen_n_q <= wen_n_d;
      ren_n_q <= ren_n_d;
      wd_q <= wd_d;
      cap_q <= cap_d;
      in_packet_q <= in_packet_d;
      prs_n_q <= prs_n_d;
      prs_cnt_q <= prs_cnt_d;
      prs_st_q <= prs_st_d;
      irq_q <= irq_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  // Link drive
  assign link.packet_select_strap = strap_q;
  assign link.master_reset_n = mrst_n_q;
  assign link.queue_partial_reset_n = prs_n_q;
  assign link.write_enable_n = wen_n_q;
  assign link.write_queue_address = wq_q;
  assign link.write_queue_select_enable = wsel_en_q;
  assign link.write_data = wd_q;
  assign link.read_enable_n = ren_n_q;
  assign link.output_enable_n = 1'b0;
  assign link.read_queue_address = rq_q;
  assign link.read_queue_select_enable = rsel_en_q;
  assign rdata = rdata_q;
  assign irq = |(irq_q & mask_q);
endmodule : mqpr_host

// ---- verification/mqpr_link_chk.sv ----
// Checker for the link pins between the queue host and the queue device.
// Assumes one clock and the shared asynchronous active-low reset.
`timescale 1ns/100ps
module mqpr_link_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link pins
  input wire logic packet_select_strap,
  input wire logic master_reset_n,
  input wire logic queue_partial_reset_n,
  input wire logic write_enable_n,
  input wire logic write_queue_select_enable,
  input wire logic [mqpr_pkg::DATA_WIDTH-1:0] write_data,
  input wire logic read_enable_n,
  input wire logic output_enable_n,
  input wire logic [mqpr_pkg::QADDR_WIDTH-1:0] read_queue_address,
  input wire logic read_queue_select_enable,
  input wire logic output_valid_n,
  input wire logic packet_ready_n,
  input wire logic almost_empty_n,
  input wire logic [mqpr_pkg::QUEUE_COUNT-1:0] read_flag_bus
);
  import mqpr_pkg::*;
  logic mode_q, mode_d; // Captured mode strap
  logic rsel_q, rsel_d; // Read queue chosen since master reset
  logic ever_q, ever_d; // Read queue ever chosen
  logic inpkt_q, inpkt_d; // Writer inside a packet
  logic [2:0] age_q, age_d; // Cycles since last queue select
  logic [QADDR_WIDTH-1:0] rq_q, rq_d; // Selected read queue
  // Next values of the shadow state
  always_comb begin
    mode_d = master_reset_n ? mode_q : packet_select_strap;
    rq_d = read_queue_select_enable ? read_queue_address : rq_q;
    rsel_d = master_reset_n && (rsel_q || read_queue_select_enable);
    ever_d = ever_q || read_queue_select_enable;
    age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
    if (read_queue_select_enable || write_queue_select_enable) begin
      age_d = 3'h0;
    end
    inpkt_d = master_reset_n && inpkt_q;
    if (!write_enable_n) begin
      inpkt_d = !write_data[END_BIT] && (write_data[START_BIT] || inpkt_q);
    end
  end
  // Shadow registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {mode_q, rsel_q, ever_q, inpkt_q, age_q, rq_q} <= {4'h0, 3'h7, 3'h0};
    end else begin
      {mode_q, rsel_q, ever_q, inpkt_q, age_q, rq_q} <=
        {mode_d, rsel_d, ever_d, inpkt_d, age_d, rq_d};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // One-cycle partial reset pulse
  sequence prs_pulse_s;
    !queue_partial_reset_n ##1 queue_partial_reset_n;
  endsequence
  valid_cause_a: assert property (
    !output_valid_n |-> !$past(read_enable_n) && !$past(output_enable_n))
    else $error("word valid without a read");
  ready_off_a: assert property (
    master_reset_n && !mode_q |-> packet_ready_n) else $error("ready in almost-empty mode");
  flag_bus_a: assert property (
    master_reset_n && rsel_q |-> read_flag_bus[rq_q] == (mode_q ? packet_ready_n : almost_empty_n))
    else $error("flag bus disagrees with discrete flag");
  ae_preset_a: assert property (
    !ever_q |-> !almost_empty_n) else $error("almost empty high before select");
  prs_setup_a: assert property (
    $fell(queue_partial_reset_n) |-> age_q >= 3'h1) else $error("select too close to reset");
  prs_pulse_a: assert property (
    $fell(queue_partial_reset_n) |-> prs_pulse_s) else $error("partial reset not one cycle");
  wsel_hold_a: assert property (
    master_reset_n && mode_q && inpkt_q |-> !write_queue_select_enable)
    else $error("write queue changed inside packet");
  prs_clear_a: assert property (
    $rose(queue_partial_reset_n) |-> packet_ready_n && !almost_empty_n)
    else $error("queue not emptied by partial reset");
endmodule : mqpr_link_chk

// ---- verification/tb_top.sv ----
// Testbench: software port stimulus of host, device behind it, link checker.
// Assumes the host register map of the package.
`timescale 1ns/100ps
module tb_top;
  import mqpr_pkg::*;
  logic clk = 1'b0; // Bench clock
  logic rst_b = 1'b0; // Reset
  logic [3:0] addr = 4'h0; // Software port
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic [31:0] v; // Read result
  int n_fail = 0;
  int cmp_count = 0;
  always #20 clk = ~clk;
  mqpr_link_if lk ();
  mqpr_device i_mqpr_device (.clk(clk), .rst_b(rst_b), .link(lk));
  mqpr_host i_mqpr_host (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .irq(irq), .link(lk));
  mqpr_link_chk i_mqpr_link_chk (.clk(clk), .rst_b(rst_b),
    .packet_select_strap(lk.packet_select_strap), .master_reset_n(lk.master_reset_n),
    .queue_partial_reset_n(lk.queue_partial_reset_n), .write_enable_n(lk.write_enable_n),
    .write_queue_select_enable(lk.write_queue_select_enable), .write_data(lk.write_data),
    .read_enable_n(lk.read_enable_n), .output_enable_n(lk.output_enable_n),
    .read_queue_address(lk.read_queue_address),
    .read_queue_select_enable(lk.read_queue_select_enable),
    .output_valid_n(lk.output_valid_n), .packet_ready_n(lk.packet_ready_n),
    .almost_empty_n(lk.almost_empty_n), .read_flag_bus(lk.read_flag_bus));
  // Compare and count
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Counts and verdict
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  // Bounded wait ran out
  task automatic timed_out();
    n_fail++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    tally_and_finish();
  endtask : timed_out
  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  // One-cycle register read, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd
  // Store one word with its markers {end, start}
  task automatic put(input logic [31:0] p, input logic [1:0] m);
    wr(REG_STATUS, p);
    wr(REG_WDATA, {26'h0, m, 4'h0});
  endtask : put
  // Flags after the last request has landed
  task automatic pins(input logic r, input logic a);
    @(posedge clk);
    @(negedge clk);
    chk(lk.packet_ready_n, r);
    chk(lk.almost_empty_n, a);
  endtask : pins
  // Pop one word and check it, with the ready flag seen beside it
  task automatic pop(input logic [35:0] e, input logic r);
    wr(REG_READ, 32'h0);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      if (lk.output_valid_n === 1'b0) begin
        chk({2'b00, lk.read_data[33:0]}, e);
        chk(lk.packet_ready_n, r);
        return;
      end
    end
    timed_out();
  endtask : pop
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // Packet mode: open packet, complete packet, other queue
    wr(REG_CTRL, 32'h3);
    wr(REG_CTRL, 32'h1);
    wr(REG_WSEL, 32'h2);
    wr(REG_RSEL, 32'h2);
    put(32'hA5A5_0001, 2'b01);
    wr(REG_WSEL, 32'h5);
    put(32'h0000_0002, 2'b00);
    pins(1'b1, 1'b0);
    put(32'h5A5A_0003, 2'b10);
    pins(1'b0, 1'b1);
    wr(REG_RSEL, 32'h5);
    pins(1'b1, 1'b0);
    chk(lk.read_flag_bus, 8'hFB);
    wr(REG_RSEL, 32'h2);
    pop({4'h1, 32'hA5A5_0001}, 1'b0);
    pins(1'b0, 1'b0);
    pop({4'h0, 32'h0000_0002}, 1'b0);
    pop({4'h2, 32'h5A5A_0003}, 1'b1);
    pins(1'b1, 1'b0);
    rd(REG_RDATA, v);
    chk(v, 32'h5A5A_0003);
    $display("packet mode test done");
    // Interrupt: masked, unmasked, cleared
    wr(REG_MASK, 32'h0);
    @(negedge clk);
    chk(irq, 1'b0);
    rd(REG_IRQ, v);
    chk(v, 32'h3);
    wr(REG_MASK, 32'h1);
    @(negedge clk);
    chk(irq, 1'b1);
    wr(REG_IRQ, 32'h1);
    @(negedge clk);
    chk(irq, 1'b0);
    rd(4'hF, v);
    chk(v, 32'h0);
    $display("interrupt test done");
    // Partial reset of queue 3 with queue 1 holding a packet
    wr(REG_WSEL, 32'h1);
    put(32'h0000_0011, 2'b11);
    wr(REG_WSEL, 32'h3);
    wr(REG_RSEL, 32'h3);
    put(32'h0000_0031, 2'b01);
    put(32'h0000_0032, 2'b00);
    put(32'h0000_0033, 2'b10);
    pins(1'b0, 1'b1);
    wr(REG_CTRL, 32'h5);
    v = 32'h4;
    for (int i = 0; i < 20 && v[2]; i++) begin
      rd(REG_CTRL, v);
    end
    if (v[2] !== 1'b0) begin
      timed_out();
    end
    pins(1'b1, 1'b0);
    rd(REG_IRQ, v);
    chk(v, 32'h6);
    wr(REG_RSEL, 32'h1);
    pins(1'b0, 1'b0);
    pop({4'h3, 32'h0000_0011}, 1'b1);
    $display("partial reset test done");
    // Almost-empty mode
    wr(REG_CTRL, 32'h2);
    wr(REG_CTRL, 32'h0);
    wr(REG_WSEL, 32'h0);
    wr(REG_RSEL, 32'h0);
    put(32'h0000_0041, 2'b11);
    put(32'h0000_0042, 2'b00);
    put(32'h0000_0043, 2'b00);
    pins(1'b1, 1'b1);
    chk(lk.read_flag_bus, 8'h01);
    $display("almost-empty mode test done");
    tally_and_finish();
  end
endmodule : tb_top
